// ---- pkg/usc_pkg.sv ----
// Constants for the serial unit control and configuration block.
// Assumes a 20 MHz register clock; all other files except the pad peer model import this package.
package usc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	// Latency of the core-domain synchronisation handshake
	localparam int unsigned SYNC_TIME_NS = 250;
	localparam int unsigned SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SYNC_CNT_INIT = SYNC_CYCLES[3:0];

	localparam logic [7:0] OFS_CONTROL_A = 8'h00;
	localparam logic [7:0] OFS_CONTROL_B = 8'h04;
	localparam logic [7:0] OFS_DEBUG_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_SYNC = 8'h1c;

	// control_a fields
	localparam int unsigned CA_SOFT_RESET = 0;
	localparam int unsigned CA_ENABLE = 1;
	localparam int unsigned CA_MODE_LSB = 2;
	localparam int unsigned CA_RUN_STANDBY = 7;
	localparam int unsigned CA_IMM_OVF = 8;
	localparam int unsigned CA_TX_PAD = 16;
	localparam int unsigned CA_RX_PAD_LSB = 20;
	localparam int unsigned CA_FRAME_FORMAT_LSB = 24;
	// control_b fields
	localparam int unsigned CB_TX_ON = 16;
	localparam int unsigned CB_RX_ON = 17;
	// debug_control, status and sync fields
	localparam int unsigned DBG_STOP = 0;
	localparam int unsigned ST_PARITY_ERR = 0;
	localparam int unsigned ST_FRAME_ERR = 1;
	localparam int unsigned ST_OVERFLOW = 2;
	localparam int unsigned SP_SOFT_RESET = 0;
	localparam int unsigned SP_ENABLE = 1;
	localparam int unsigned SP_CONTROL_B = 2;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0] FRAME_FORMAT_PLAIN = 4'h0;
	localparam logic [3:0] FRAME_FORMAT_PARITY = 4'h1;
	localparam logic [2:0] MODE_EXT_CLK = 3'h0;
	localparam logic [2:0] MODE_INT_CLK = 3'h1;
endpackage

// ---- hdl/usc_sync_delay.sv ----
// Synchronisation delay model of the core-clock handshake.
// A start pulse arms the counter; a one-cycle done pulse ends it.
`timescale 1ns/1ps
module usc_sync_delay
	import usc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_start,
	output logic o_busy,
	output logic o_done
);
	logic [3:0] cnt_q;

	// Restart on a new request so the last write is the one reported
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 4'h0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				cnt_q <= SYNC_CNT_INIT;
				o_busy <= 1'b1;
			end else if (o_busy) begin
				if (cnt_q == 4'h1) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule

// ---- hdl/usc_control.sv ----
// Control and configuration registers of the serial unit in USART mode.
// Assumes an APB peripheral port and a data path that reports its events.
`timescale 1ns/1ps
// Functional notes
// - frame_format 0 gives plain frame, 1 adds parity; other codes reserved.
// - rx_pad_select picks which of four lanes feeds serial receive data.
// - tx_pad_select 0 puts data on lane 0 and clock on 1; 1 uses 2 and 3.
// - overflow flag set in stream order, or at once when immediate notify set.
// - External clock, no standby run: disconnect after transfer, drop reception.
// - Internal clock, no standby run: stop core clock; wake on start or complete.
// - Standby run keeps clock; any wake internally, receive wakes externally.
// - Mode 0 is externally clocked, mode 1 internally clocked.
// - Enable reads back at once; its pending flag clears when done.
// - Soft reset one resets all but debug_control and disables; zero ignored.
// - A soft reset write discards every other bit of that write.
// - During soft reset writes give error, reads give reset values; sync and debug_control read live, control_a reads its soft reset bit set.
// - Soft reset bit and its pending flag clear together when done.
// - Receiver off flushes buffer and clears frame, parity and overflow flags.
// - Receiver on sets at once if disabled, else after pending sync ends.
// - Transmitter off waits until ongoing and pending transmissions finish.
// - Transmitter on sets at once if disabled, else after pending sync ends.
// - control_b writable only when disabled, except receiver and transmitter bits.
module usc_control
	import usc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [3:0] i_lane_in,
	output logic [3:0] o_lane_out,
	output logic [3:0] o_lane_oe_n,
	input wire logic i_tx_data,
	input wire logic i_xck_out,
	output logic o_rx_data,
	input wire logic i_tx_busy,
	input wire logic i_rx_busy,
	input wire logic i_ovf_now,
	input wire logic i_ovf_in_stream,
	input wire logic i_frame_err,
	input wire logic i_parity_err,
	input wire logic i_standby,
	input wire logic i_irq_rx_start,
	input wire logic i_irq_rx_done,
	input wire logic i_irq_tx_done,
	input wire logic i_irq_any,
	output logic o_unit_on,
	output logic o_rx_on,
	output logic o_tx_on,
	output logic o_rx_flush,
	output logic o_parity_en,
	output logic o_clk_internal,
	output logic o_core_clk_en,
	output logic o_ext_clk_conn,
	output logic o_rx_drop,
	output logic o_wake,
	output logic o_dbg_stop
);
	logic soft_reset_request_q, enable_q, run_stby_q, imm_ovf_q, tx_pad_q;
	logic [2:0] mode_q;
	logic [1:0] rx_pad_q;
	logic [3:0] frame_format_q;
	logic receiver_on_q, transmitter_on_q, rx_arm_q, tx_arm_q;
	logic sp_enable_q, sp_control_b_q;
	logic ovf_q, frame_error_flag_q, parity_error_flag_q;
	logic stopped_q;
	logic sync_busy, sync_done;
	logic setup, wr, err_d, mapped, srst_done, sync_start;
	logic wa, wb, soft_reset_request_wr, disabled, rx_off_wr, clr_all, w1c;
	logic [31:0] ctla_word, rd_d;

	assign setup = i_psel && !i_penable;
	assign wr = setup && i_pwrite;
	assign mapped = i_paddr == OFS_CONTROL_A || i_paddr == OFS_CONTROL_B ||
		i_paddr == OFS_DEBUG_CTRL || i_paddr == OFS_STATUS || i_paddr == OFS_SYNC;
	assign err_d = (wr && soft_reset_request_q) || (setup && !mapped);
	assign wa = wr && !soft_reset_request_q && i_paddr == OFS_CONTROL_A;
	assign wb = wr && !soft_reset_request_q && i_paddr == OFS_CONTROL_B;
	assign soft_reset_request_wr = wa && i_pstrb[0] && i_pwdata[CA_SOFT_RESET];
	assign disabled = !enable_q && !o_unit_on;
	assign rx_off_wr = wb && i_pstrb[2] && !i_pwdata[CB_RX_ON];
	assign srst_done = sync_done && soft_reset_request_q;
	assign clr_all = rx_off_wr || srst_done;
	assign w1c = wr && !soft_reset_request_q && i_paddr == OFS_STATUS && i_pstrb[0];
	assign sync_start = soft_reset_request_wr || (wa && i_pstrb[0]) ||
		(wb && i_pstrb[2] && o_unit_on && (i_pwdata[CB_RX_ON] || i_pwdata[CB_TX_ON]));

	usc_sync_delay u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_start(sync_start),
		.o_busy(sync_busy),
		.o_done(sync_done)
	);

	// control_a: soft reset dominates, config only while disabled
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			soft_reset_request_q <= 1'b0;
			enable_q <= 1'b0;
			sp_enable_q <= 1'b0;
			run_stby_q <= 1'b0;
			imm_ovf_q <= 1'b0;
			tx_pad_q <= 1'b0;
			mode_q <= 3'h0;
			rx_pad_q <= 2'h0;
			frame_format_q <= 4'h0;
			o_unit_on <= 1'b0;
		end else if (srst_done) begin
			soft_reset_request_q <= 1'b0;
			enable_q <= 1'b0;
			sp_enable_q <= 1'b0;
			run_stby_q <= 1'b0;
			imm_ovf_q <= 1'b0;
			tx_pad_q <= 1'b0;
			mode_q <= 3'h0;
			rx_pad_q <= 2'h0;
			frame_format_q <= 4'h0;
			o_unit_on <= 1'b0;
		end else if (soft_reset_request_wr) begin
			soft_reset_request_q <= 1'b1;
		end else begin
			if (sync_done && sp_enable_q) begin
				sp_enable_q <= 1'b0;
				o_unit_on <= enable_q;
			end
			if (wa && i_pstrb[0]) begin
				enable_q <= i_pwdata[CA_ENABLE];
				sp_enable_q <= 1'b1;
			end
			if (wa && disabled) begin
				if (i_pstrb[0]) begin
					run_stby_q <= i_pwdata[CA_RUN_STANDBY];
					mode_q <= i_pwdata[CA_MODE_LSB +: 3];
				end
				if (i_pstrb[1]) begin
					imm_ovf_q <= i_pwdata[CA_IMM_OVF];
				end
				if (i_pstrb[2]) begin
					tx_pad_q <= i_pwdata[CA_TX_PAD];
					rx_pad_q <= i_pwdata[CA_RX_PAD_LSB +: 2];
				end
				if (i_pstrb[3]) begin
					frame_format_q <= i_pwdata[CA_FRAME_FORMAT_LSB +: 4];
				end
			end
		end
	end

	// control_b receiver and transmitter enables
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			receiver_on_q <= 1'b0;
			transmitter_on_q <= 1'b0;
			rx_arm_q <= 1'b0;
			tx_arm_q <= 1'b0;
			sp_control_b_q <= 1'b0;
		end else if (srst_done) begin
			receiver_on_q <= 1'b0;
			transmitter_on_q <= 1'b0;
			rx_arm_q <= 1'b0;
			tx_arm_q <= 1'b0;
			sp_control_b_q <= 1'b0;
		end else begin
			if (sync_done && sp_control_b_q) begin
				sp_control_b_q <= 1'b0;
				receiver_on_q <= receiver_on_q || rx_arm_q;
				transmitter_on_q <= transmitter_on_q || tx_arm_q;
				rx_arm_q <= 1'b0;
				tx_arm_q <= 1'b0;
			end
			if (wb && i_pstrb[2]) begin
				if (!i_pwdata[CB_RX_ON]) begin
					receiver_on_q <= 1'b0;
					rx_arm_q <= 1'b0;
				end else if (o_unit_on) begin
					rx_arm_q <= 1'b1;
					sp_control_b_q <= 1'b1;
				end else begin
					receiver_on_q <= 1'b1;
				end
				if (!i_pwdata[CB_TX_ON]) begin
					transmitter_on_q <= 1'b0;
					tx_arm_q <= 1'b0;
				end else if (o_unit_on) begin
					tx_arm_q <= 1'b1;
					sp_control_b_q <= 1'b1;
				end else begin
					transmitter_on_q <= 1'b1;
				end
			end
		end
	end

	// Running state of receiver and transmitter
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rx_on <= 1'b0;
			o_tx_on <= 1'b0;
			o_rx_flush <= 1'b0;
		end else begin
			o_rx_on <= o_unit_on && receiver_on_q;
			o_rx_flush <= rx_off_wr || srst_done;
			if (o_unit_on && transmitter_on_q) begin
				o_tx_on <= 1'b1;
			end else if (!i_tx_busy) begin
				o_tx_on <= 1'b0;
			end
		end
	end

	// Status flags; a set in the clearing cycle wins
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ovf_q <= 1'b0;
			frame_error_flag_q <= 1'b0;
			parity_error_flag_q <= 1'b0;
		end else begin
			if (imm_ovf_q ? i_ovf_now : i_ovf_in_stream) begin
				ovf_q <= 1'b1;
			end else if (clr_all || (w1c && i_pwdata[ST_OVERFLOW])) begin
				ovf_q <= 1'b0;
			end
			if (i_frame_err) begin
				frame_error_flag_q <= 1'b1;
			end else if (clr_all || (w1c && i_pwdata[ST_FRAME_ERR])) begin
				frame_error_flag_q <= 1'b0;
			end
			if (i_parity_err) begin
				parity_error_flag_q <= 1'b1;
			end else if (clr_all || (w1c && i_pwdata[ST_PARITY_ERR])) begin
				parity_error_flag_q <= 1'b0;
			end
		end
	end

	// Debug control survives soft reset
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_dbg_stop <= 1'b0;
		end else if (wr && !soft_reset_request_q && i_paddr == OFS_DEBUG_CTRL && i_pstrb[0]) begin
			o_dbg_stop <= i_pwdata[DBG_STOP];
		end
	end

	// Register read mux
	always_comb begin
		ctla_word = RST_WORD;
		ctla_word[CA_SOFT_RESET] = soft_reset_request_q;
		ctla_word[CA_ENABLE] = enable_q;
		ctla_word[CA_MODE_LSB +: 3] = mode_q;
		ctla_word[CA_RUN_STANDBY] = run_stby_q;
		ctla_word[CA_IMM_OVF] = imm_ovf_q;
		ctla_word[CA_TX_PAD] = tx_pad_q;
		ctla_word[CA_RX_PAD_LSB +: 2] = rx_pad_q;
		ctla_word[CA_FRAME_FORMAT_LSB +: 4] = frame_format_q;
		rd_d = RST_WORD;
		unique case (i_paddr)
			OFS_CONTROL_A: rd_d = ctla_word;
			OFS_CONTROL_B: begin
				rd_d[CB_RX_ON] = receiver_on_q;
				rd_d[CB_TX_ON] = transmitter_on_q;
			end
			OFS_DEBUG_CTRL: rd_d[DBG_STOP] = o_dbg_stop;
			OFS_STATUS: begin
				rd_d[ST_OVERFLOW] = ovf_q;
				rd_d[ST_FRAME_ERR] = frame_error_flag_q;
				rd_d[ST_PARITY_ERR] = parity_error_flag_q;
			end
			OFS_SYNC: begin
				rd_d[SP_SOFT_RESET] = soft_reset_request_q;
				rd_d[SP_ENABLE] = sp_enable_q;
				rd_d[SP_CONTROL_B] = sp_control_b_q;
			end
			default: rd_d = RST_WORD;
		endcase
		if (soft_reset_request_q && i_paddr != OFS_SYNC && i_paddr != OFS_DEBUG_CTRL) begin
			rd_d = RST_WORD;
			rd_d[CA_SOFT_RESET] = i_paddr == OFS_CONTROL_A;
		end
	end

	// APB answer in the access phase, no wait states
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= setup;
			o_pslverr <= setup && err_d;
			o_prdata <= (setup && !i_pwrite) ? rd_d : 32'h0000_0000;
		end
	end

	// Pad routing, frame and clock decode
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_lane_out <= 4'h0;
			o_lane_oe_n <= 4'hf;
			o_rx_data <= 1'b1;
			o_parity_en <= 1'b0;
			o_clk_internal <= 1'b0;
		end else begin
			o_rx_data <= i_lane_in[rx_pad_q];
			o_parity_en <= frame_format_q == FRAME_FORMAT_PARITY;
			o_clk_internal <= mode_q == MODE_INT_CLK;
			o_lane_out <= 4'h0;
			o_lane_oe_n <= 4'hf;
			o_lane_out[{tx_pad_q, 1'b0}] <= i_tx_data;
			o_lane_oe_n[{tx_pad_q, 1'b0}] <= !o_tx_on;
			o_lane_out[{tx_pad_q, 1'b1}] <= i_xck_out;
			o_lane_oe_n[{tx_pad_q, 1'b1}] <= !(o_tx_on && mode_q == MODE_INT_CLK);
		end
	end

	// Standby clock handling and wake requests
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			stopped_q <= 1'b0;
			o_core_clk_en <= 1'b1;
			o_ext_clk_conn <= 1'b1;
			o_rx_drop <= 1'b0;
			o_wake <= 1'b0;
		end else begin
			if (!i_standby || run_stby_q) begin
				stopped_q <= 1'b0;
			end else if (!i_tx_busy && !i_rx_busy) begin
				stopped_q <= 1'b1;
			end
			o_core_clk_en <= !(stopped_q && mode_q == MODE_INT_CLK);
			o_ext_clk_conn <= !(stopped_q && mode_q == MODE_EXT_CLK);
			o_rx_drop <= stopped_q && mode_q == MODE_EXT_CLK;
			if (!i_standby) begin
				o_wake <= 1'b0;
			end else if (mode_q == MODE_INT_CLK) begin
				o_wake <= run_stby_q ? i_irq_any : (i_irq_rx_start || i_irq_tx_done);
			end else begin
				o_wake <= run_stby_q && (i_irq_rx_start || i_irq_rx_done);
			end
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	a_soft_reset_request_write_err: assert property (
		(wr && soft_reset_request_q) |=> (o_pready && o_pslverr))
		else $error("write during soft reset not refused");
	a_soft_reset_request_clear_pair: assert property (
		soft_reset_request_q |=> (soft_reset_request_q != $past(sync_done)))
		else $error("soft reset state lost");
	a_soft_reset_request_ends: assert property (
		$rose(soft_reset_request_q) |-> ##[1:6] (!soft_reset_request_q && !enable_q && !o_unit_on && !transmitter_on_q))
		else $error("soft reset did not complete with unit disabled");
	a_soft_reset_request_priority: assert property (
		soft_reset_request_wr |=> ($stable(enable_q) && $stable(frame_format_q) && $stable(mode_q)))
		else $error("other bits taken with soft reset");
	a_enable_readback: assert property (
		(wa && i_pstrb[0] && !soft_reset_request_wr) |=> (enable_q == $past(i_pwdata[CA_ENABLE]) && sp_enable_q))
		else $error("enable readback or pending flag wrong");
	a_enable_done: assert property (
		$fell(sp_enable_q) && !soft_reset_request_q |-> o_unit_on == enable_q)
		else $error("pending cleared before enable took effect");
	a_rx_off_flush: assert property (
		rx_off_wr |=> (o_rx_flush && !receiver_on_q) ##1 !o_rx_on)
		else $error("receiver off did not flush");
	a_tx_stop_wait: assert property (
		(o_tx_on && i_tx_busy) |=> o_tx_on)
		else $error("transmitter stopped during transfer");
	a_ovf_immediate: assert property (
		(imm_ovf_q && i_ovf_now) |=> ovf_q)
		else $error("immediate overflow not flagged");
	a_rx_lane_route: assert property (
		$stable(rx_pad_q) |=> o_rx_data == $past(i_lane_in[rx_pad_q]))
		else $error("receive lane routing wrong");
	a_rx_on_pending: assert property (
		(wb && i_pstrb[2] && i_pwdata[CB_RX_ON] && o_unit_on && !receiver_on_q) |=> (!receiver_on_q && sp_control_b_q))
		else $error("receiver bit set before sync");
	a_ext_drop: assert property (
		(stopped_q && mode_q == MODE_EXT_CLK) |=> (o_rx_drop && !o_ext_clk_conn))
		else $error("external clock not disconnected in standby");

	c_soft_reset: cover property ($fell(soft_reset_request_q));
	c_enable_sync: cover property ($fell(sp_enable_q) && o_unit_on);
	c_rx_armed: cover property ($fell(sp_control_b_q) && receiver_on_q);
	c_standby_stop: cover property ($rose(stopped_q));
endmodule

// ---- tb/usc_peer.sv ----
// Serial peer on the four pad wires of the unit.
// Assumes active-low pad enables; the peer drives a wire only where the unit does not.
`timescale 1ns/1ps
module usc_peer (
	input wire logic [3:0] i_pat,
	input wire logic [3:0] i_lane_out,
	input wire logic [3:0] i_lane_oe_n,
	output logic [3:0] o_wire
);
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			o_wire[k] = i_lane_oe_n[k] ? i_pat[k] : i_lane_out[k];
		end
	end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the control block, driven over its register port.
// Assumes the package constants and a 20 MHz clock.
`timescale 1ns/1ps
module tb_top
	import usc_pkg::*;
;
	typedef struct {logic [31:0] ca; logic par; logic intl;} usc_row_s;
	usc_row_s rows[4] = '{'{32'h0000_0000, 1'b0, 1'b0}, '{32'h0111_0004, 1'b1, 1'b1},
		'{32'h0220_0008, 1'b0, 1'b0}, '{32'h0031_0004, 1'b0, 1'b1}};
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, rx_data, tx_data = 0, ext_serial_clock = 0, tx_busy = 0, rx_busy = 0;
	logic ovf_now = 0, ovf_str = 0, frame_error_flag = 0, parity_error_flag = 0, stby = 0, irq_rs = 0, irq_rd = 0;
	logic irq_td = 0, irq_any = 0, unit_on, rx_on, tx_on, flush, par_en, clk_int, core_en;
	logic ext_conn, rx_drop, wake, dbg_stop;
	logic [3:0] pat = 4'h0, lane_out, lane_oe_n, wires;
	int fail_count = 0, samples_checked = 0, flushes = 0, dl;

	usc_control u_dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_lane_in(wires),
		.o_lane_out(lane_out), .o_lane_oe_n(lane_oe_n), .i_tx_data(tx_data), .i_xck_out(ext_serial_clock),
		.o_rx_data(rx_data), .i_tx_busy(tx_busy), .i_rx_busy(rx_busy), .i_ovf_now(ovf_now),
		.i_ovf_in_stream(ovf_str), .i_frame_err(frame_error_flag), .i_parity_err(parity_error_flag), .i_standby(stby),
		.i_irq_rx_start(irq_rs), .i_irq_rx_done(irq_rd), .i_irq_tx_done(irq_td),
		.i_irq_any(irq_any), .o_unit_on(unit_on), .o_rx_on(rx_on), .o_tx_on(tx_on),
		.o_rx_flush(flush), .o_parity_en(par_en), .o_clk_internal(clk_int),
		.o_core_clk_en(core_en), .o_ext_clk_conn(ext_conn), .o_rx_drop(rx_drop), .o_wake(wake),
		.o_dbg_stop(dbg_stop));
	usc_peer u_peer (.i_pat(pat), .i_lane_out(lane_out), .i_lane_oe_n(lane_oe_n), .o_wire(wires));

	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (flush === 1'b1) flushes++;
	end

	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Setup edge, access edge, then one idle cycle
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel = 1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		step(1);
		penable = 1;
		n = 0;
		while (pready !== 1'b1 && n < 8) begin
			step(1);
			n++;
		end
		r = prdata;
		e = pslverr;
		step(1);
		psel = 0;
		penable = 0;
		step(1);
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
		apb(0, a, 32'h0);
		cmp(nm, ex, r);
	endtask
	task wsync;
		int n;
		n = 0;
		do begin
			apb(0, OFS_SYNC, 32'h0);
			n++;
		end while (r !== 32'h0 && n < 20);
		cmp("sync idle", 32'h0, r);
	endtask
	task recfg(input logic [31:0] ca);
		apb(1, OFS_CONTROL_A, 32'h0);
		wsync();
		apb(1, OFS_CONTROL_A, ca);
		apb(1, OFS_CONTROL_A, ca | 32'h2);
		wsync();
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		#1_000_000;
		fail_count++;
		test_done();
	end

	initial begin
		step(10);
		rst = 0;
		foreach (rows[i]) begin
			apb(1, OFS_CONTROL_A, rows[i].ca);
			rd("control_a", OFS_CONTROL_A, rows[i].ca);
			cmp("parity_en", 32'(rows[i].par), 32'(par_en));
			cmp("clk_internal", 32'(rows[i].intl), 32'(clk_int));
			pat = 4'h1 << rows[i].ca[21:20];
			step(2);
			cmp("rx_data high", 32'h1, 32'(rx_data));
			pat = ~pat;
			step(2);
			cmp("rx_data low", 32'h0, 32'(rx_data));
			pat = 4'h0;
			tx_data = 1;
			ext_serial_clock = 1;
			apb(1, OFS_CONTROL_B, 32'h0001_0000);
			rd("tx bit at once", OFS_CONTROL_B, 32'h0001_0000);
			apb(1, OFS_CONTROL_A, rows[i].ca | 32'h2);
			wsync();
			cmp("tx_on", 32'h1, 32'(tx_on));
			dl = rows[i].ca[16] ? 2 : 0;
			cmp("tx lane", 32'h1, 32'(wires[dl]));
			cmp("clock lane", 32'(rows[i].intl), 32'(wires[dl + 1]));
			apb(1, OFS_CONTROL_B, 32'h0);
			apb(1, OFS_CONTROL_A, rows[i].ca);
			wsync();
			tx_data = 0;
			ext_serial_clock = 0;
			$display("test row %0d done", i);
		end
		rst = 1;
		step(2);
		rst = 0;
		rd("control_a", OFS_CONTROL_A, 32'h0);
		rd("control_b", OFS_CONTROL_B, 32'h0);
		rd("status", OFS_STATUS, 32'h0);
		cmp("pads", 32'hf, 32'(lane_oe_n));
		cmp("clocks", 32'h3, 32'({core_en, ext_conn}));
		apb(0, 8'h3c, 32'h0);
		cmp("unmapped err", 32'h1, 32'(e));
		$display("test reset done");
		apb(1, OFS_CONTROL_A, 32'h4);
		apb(1, OFS_CONTROL_A, 32'h6);
		rd("sync enable", OFS_SYNC, 32'h2);
		rd("enable readback", OFS_CONTROL_A, 32'h6);
		wsync();
		cmp("unit_on", 32'h1, 32'(unit_on));
		apb(1, OFS_CONTROL_B, 32'h0002_0001);
		rd("sync control_b", OFS_SYNC, 32'h4);
		wsync();
		rd("rx on", OFS_CONTROL_B, 32'h0002_0000);
		cmp("rx_on", 32'h1, 32'(rx_on));
		ovf_now = 1;
		step(1);
		ovf_now = 0;
		rd("ovf deferred", OFS_STATUS, 32'h0);
		{ovf_str, frame_error_flag, parity_error_flag} = 3'h7;
		step(1);
		{ovf_str, frame_error_flag, parity_error_flag} = 3'h0;
		rd("flags", OFS_STATUS, 32'h7);
		flushes = 0;
		apb(1, OFS_CONTROL_B, 32'h0);
		rd("flags flushed", OFS_STATUS, 32'h0);
		cmp("flush pulses", 32'h1, 32'(flushes));
		apb(1, OFS_CONTROL_B, 32'h0001_0000);
		wsync();
		tx_busy = 1;
		apb(1, OFS_CONTROL_B, 32'h0);
		step(4);
		cmp("tx held", 32'h1, 32'(tx_on));
		tx_busy = 0;
		step(3);
		cmp("tx off", 32'h0, 32'(tx_on));
		$display("test enable done");
		tx_busy = 1;
		stby = 1;
		step(3);
		cmp("clock kept", 32'h1, 32'(core_en));
		tx_busy = 0;
		step(3);
		cmp("clock stopped", 32'h0, 32'(core_en));
		irq_any = 1;
		step(2);
		cmp("no wake", 32'h0, 32'(wake));
		irq_rs = 1;
		step(2);
		cmp("wake", 32'h1, 32'(wake));
		{stby, irq_rs} = 2'b00;
		step(2);
		recfg(32'h0);
		stby = 1;
		step(3);
		cmp("ext standby", 32'h1, 32'({ext_conn, rx_drop}));
		stby = 0;
		step(2);
		recfg(32'h84);
		stby = 1;
		step(3);
		cmp("run standby", 32'h3, 32'({core_en, wake}));
		{stby, irq_any} = 2'b00;
		step(2);
		recfg(32'h80);
		{stby, irq_rd} = 2'b11;
		step(3);
		cmp("ext wake", 32'h1, 32'(wake));
		{stby, irq_rd} = 2'b00;
		$display("test standby done");
		apb(1, OFS_DEBUG_CTRL, 32'h1);
		apb(1, OFS_CONTROL_A, 32'h0);
		wsync();
		apb(1, OFS_CONTROL_A, 32'h0000_0100);
		wsync();
		apb(1, OFS_CONTROL_B, 32'h0002_0000);
		rd("rx bit at once", OFS_CONTROL_B, 32'h0002_0000);
		apb(1, OFS_CONTROL_A, 32'h0000_0102);
		wsync();
		cmp("rx_on", 32'h1, 32'(rx_on));
		ovf_now = 1;
		step(1);
		ovf_now = 0;
		rd("ovf immediate", OFS_STATUS, 32'h4);
		for (int k = 0; k < 3; k++) begin
			apb(1, OFS_CONTROL_A, 32'h0100_0001);
			if (k == 0) rd("soft_reset_request bit", OFS_CONTROL_A, 32'h1);
			if (k == 1) rd("soft_reset_request sync", OFS_SYNC, 32'h1);
			if (k == 2) apb(1, OFS_CONTROL_B, 32'h0001_0000);
			if (k == 2) cmp("write err", 32'h1, 32'(e));
			wsync();
		end
		rd("control_a reset", OFS_CONTROL_A, 32'h0);
		rd("control_b reset", OFS_CONTROL_B, 32'h0);
		rd("debug kept", OFS_DEBUG_CTRL, 32'h1);
		cmp("outputs", 32'h1, 32'({unit_on, par_en, rx_on, dbg_stop}));
		$display("test soft reset done");
		test_done();
	end
endmodule
